// ===== src/csi_map.vh
// Constants for the compare-and-skip execution unit
`ifndef CSI_MAP_VH
`define CSI_MAP_VH

// ----------------------------------------------------------------------
// Quarter cycles
// ----------------------------------------------------------------------
`define CSI_Q1            2'h0
`define CSI_Q2            2'h1
`define CSI_Q3            2'h2
`define CSI_Q4            2'h3

// ----------------------------------------------------------------------
// Opcode fields
// ----------------------------------------------------------------------
`define CSI_OP_CMP_LT     7'h30
`define CSI_OP_CMP_EQ     7'h31
`define CSI_OP_CMP_GT     7'h32
`define CSI_OP_COMPL      6'h07
`define CSI_BIT_BANKSEL   8
`define CSI_BIT_DEST      9

// ----------------------------------------------------------------------
// Addressing
// ----------------------------------------------------------------------
`define CSI_ADDR_W        12
`define CSI_MEM_DEPTH     4096
`define CSI_INDEX_LIMIT   8'h5f
`define CSI_ACCESS_SPLIT  8'h60
`define CSI_ACCESS_HIGH   4'hf
`define CSI_ACCESS_LOW    4'h0

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define CSI_RST_WORK      8'h00
`define CSI_RST_INSTR     16'h0000

`endif

// ===== src/csi_dmem.v
// Data memory with registered read data
`timescale 1ns/1ps
`default_nettype none
`include "csi_map.vh"

module csi_dmem (
  input  wire                     clk,
  input  wire                     wr_en,
  input  wire [`CSI_ADDR_W-1:0]   wr_addr,
  input  wire [7:0]               wr_data,
  input  wire [`CSI_ADDR_W-1:0]   rd_addr,
  output reg  [7:0]               rd_data
);

  // --------------------------------------------------------------------
  // Storage
  // --------------------------------------------------------------------
  // Contents undefined at power-up, as for any plain RAM
  reg [7:0] mem [0:`CSI_MEM_DEPTH-1];

  always @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end

endmodule
`default_nettype wire

// ===== src/csi_core.v
// Compare-and-skip execution unit with quarter-cycle sequencing
`timescale 1ns/1ps
`default_nettype none
`include "csi_map.vh"

// Overview of operation
// - Equal compare by unsigned subtraction; on equality next instruction becomes no-op.
// - Greater compare skips only when data byte exceeds working register, unsigned.
// - Less compare skips only when data byte is below working register, unsigned.
// - Compares change no status flag; difference only decides the skip.
// - Greater compare decoded from upper byte 0110 010a.
// - Less compare decoded from upper byte 0110 000a.
// - Bank bit 0 selects access bank; bit 1 uses bank select register.
// - Bank bit 0 with extended set uses indexed offset for f up to 5Fh.
// - One word; one cycle, two with skip, three skipping two-word instruction.
// - Q1 decode, Q2 read, Q3 process, Q4 no write; skip cycles all no-op.
// - Complement with destination 0 writes inverted byte to working register only.

module csi_core (
  input  wire                     CLOCK,
  input  wire                     RST_N,
  input  wire [15:0]              INSTR_WORD,
  input  wire                     NEXT_IS_TWO_WORD,
  input  wire                     EXT_SET_EN,
  input  wire [3:0]               BANK_SELECT_REGISTER,
  input  wire [`CSI_ADDR_W-1:0]   INDEX_BASE,
  input  wire                     WORK_LOAD,
  input  wire [7:0]               WORK_LOAD_DATA,
  input  wire                     MEM_WR_EN,
  input  wire [`CSI_ADDR_W-1:0]   MEM_WR_ADDR,
  input  wire [7:0]               MEM_WR_DATA,
  output wire [1:0]               QUARTER,
  output wire                     INSTR_TAKE,
  output wire                     INSTR_DONE,
  output wire                     NOP_CYCLE,
  output reg                      SKIP_TAKEN,
  output reg  [7:0]               WORKING_REGISTER,
  output reg                      STATUS_N,
  output reg                      STATUS_Z,
  output reg  [7:0]               COMPARE_DATA
);

  // --------------------------------------------------------------------
  // Sequencer states
  // --------------------------------------------------------------------
  localparam [1:0] ST_EXEC  = 2'h0;
  localparam [1:0] ST_SKIP2 = 2'h1;
  localparam [1:0] ST_SKIP1 = 2'h2;

  reg  [1:0]              q_r;
  reg  [1:0]              q_nxt;
  reg  [1:0]              state_r;
  reg  [1:0]              state_nxt;
  reg  [15:0]             instr_r;
  reg                     two_word_r;
  reg                     skip_r;
  reg                     skip_nxt;
  wire [7:0]              rd_data;
  wire [`CSI_ADDR_W-1:0]  eff_addr;
  wire                    core_wr;
  wire [`CSI_ADDR_W-1:0]  mem_wa;
  wire [7:0]              mem_wd;
  wire [8:0]              diff;
  wire                    is_eq;
  wire                    is_gt;
  wire                    is_lt;
  wire                    is_cmp;
  wire                    is_compl;
  wire                    last_q;

  // --------------------------------------------------------------------
  // Decode helpers
  // --------------------------------------------------------------------
  function [`CSI_ADDR_W-1:0] csi_ea;
    input [15:0]             ins;
    input                    ext;
    input [3:0]              bank;
    input [`CSI_ADDR_W-1:0]  base;
    begin
      if (ins[`CSI_BIT_BANKSEL]) begin
        csi_ea = {bank, ins[7:0]};
      end else if (ext && (ins[7:0] <= `CSI_INDEX_LIMIT)) begin
        csi_ea = base + {4'h0, ins[7:0]};
      end else if (ins[7:0] >= `CSI_ACCESS_SPLIT) begin
        csi_ea = {`CSI_ACCESS_HIGH, ins[7:0]};
      end else begin
        csi_ea = {`CSI_ACCESS_LOW, ins[7:0]};
      end
    end
  endfunction

  function csi_match7;
    input [15:0] ins;
    input [6:0]  op;
    begin
      csi_match7 = (ins[15:9] == op);
    end
  endfunction

  assign is_lt    = csi_match7(instr_r, `CSI_OP_CMP_LT);
  assign is_eq    = csi_match7(instr_r, `CSI_OP_CMP_EQ);
  assign is_gt    = csi_match7(instr_r, `CSI_OP_CMP_GT);
  assign is_cmp   = is_lt | is_eq | is_gt;
  assign is_compl = (instr_r[15:10] == `CSI_OP_COMPL);

  // Address computed from the latched word so Q2 read and Q4 write agree
  assign eff_addr = csi_ea(instr_r, EXT_SET_EN, BANK_SELECT_REGISTER, INDEX_BASE);

  // Unsigned subtraction; borrow gives less, zero gives equal
  assign diff = {1'b0, rd_data} - {1'b0, WORKING_REGISTER};

  // --------------------------------------------------------------------
  // Memory
  // --------------------------------------------------------------------
  // Compares never write back, only complement with destination 1 does
  assign core_wr = (state_r == ST_EXEC) && (q_r == `CSI_Q4) && is_compl
                   && instr_r[`CSI_BIT_DEST];
  assign mem_wa  = core_wr ? eff_addr : MEM_WR_ADDR;
  assign mem_wd  = core_wr ? ~rd_data : MEM_WR_DATA;

  csi_dmem u_dmem (
    .clk     (CLOCK),
    .wr_en   (core_wr | MEM_WR_EN),
    .wr_addr (mem_wa),
    .wr_data (mem_wd),
    .rd_addr (eff_addr),
    .rd_data (rd_data)
  );

  // --------------------------------------------------------------------
  // Sequencer
  // --------------------------------------------------------------------
  assign last_q     = (q_r == `CSI_Q4);
  assign QUARTER    = q_r;
  assign NOP_CYCLE  = (state_r != ST_EXEC);
  assign INSTR_TAKE = (state_r == ST_EXEC) && (q_r == `CSI_Q1);
  assign INSTR_DONE = last_q && (state_nxt == ST_EXEC);

  always @* begin
    q_nxt     = q_r + 2'h1;
    state_nxt = state_r;
    skip_nxt  = skip_r;
    case (state_r)
      ST_EXEC: begin
        if (q_r == `CSI_Q3) begin
          // Process quarter decides the skip from the Q2 read
          skip_nxt = (is_eq && (diff == 9'h000))
                   | (is_gt && !diff[8] && (diff != 9'h000))
                   | (is_lt && diff[8]);
        end
        if (last_q && skip_r) begin
          state_nxt = two_word_r ? ST_SKIP2 : ST_SKIP1;
        end
      end
      ST_SKIP2: begin
        if (last_q) begin
          state_nxt = ST_SKIP1;
        end
      end
      ST_SKIP1: begin
        if (last_q) begin
          state_nxt = ST_EXEC;
          skip_nxt  = 1'b0;
        end
      end
      default: begin
        state_nxt = ST_EXEC;
        skip_nxt  = 1'b0;
      end
    endcase
  end

  always @(posedge CLOCK) begin
    if (!RST_N) begin
      q_r        <= `CSI_Q1;
      state_r    <= ST_EXEC;
      skip_r     <= 1'b0;
      instr_r    <= `CSI_RST_INSTR;
      two_word_r <= 1'b0;
      SKIP_TAKEN <= 1'b0;
    end else begin
      q_r     <= q_nxt;
      state_r <= state_nxt;
      skip_r  <= skip_nxt;
      if (INSTR_TAKE) begin
        instr_r    <= INSTR_WORD;
        two_word_r <= NEXT_IS_TWO_WORD;
      end
      if ((state_r == ST_EXEC) && last_q) begin
        SKIP_TAKEN <= skip_r;
      end
    end
  end

  // --------------------------------------------------------------------
  // Working register, flags, read data
  // --------------------------------------------------------------------
  // Flags move only for complement; compares leave them alone
  always @(posedge CLOCK) begin
    if (!RST_N) begin
      WORKING_REGISTER <= `CSI_RST_WORK;
      STATUS_N         <= 1'b0;
      STATUS_Z         <= 1'b0;
      COMPARE_DATA     <= 8'h00;
    end else begin
      if ((state_r == ST_EXEC) && (q_r == `CSI_Q3) && is_cmp) begin
        COMPARE_DATA <= rd_data;
      end
      if ((state_r == ST_EXEC) && last_q && is_compl) begin
        STATUS_N <= ~rd_data[7];
        STATUS_Z <= (rd_data == 8'hff);
        if (!instr_r[`CSI_BIT_DEST]) begin
          WORKING_REGISTER <= ~rd_data;
        end
      end else if (WORK_LOAD) begin
        WORKING_REGISTER <= WORK_LOAD_DATA;
      end
    end
  end

endmodule
`default_nettype wire

// ===== tb/csi_core_monitor.sv
// Checker for the compare-and-skip unit
`timescale 1ns/1ps
`default_nettype none
`include "csi_map.vh"
module csi_mon (
  input wire logic        CLOCK,
  input wire logic        RST_N,
  input wire logic [15:0] INSTR_WORD,
  input wire logic [1:0]  QUARTER,
  input wire logic        INSTR_TAKE,
  input wire logic        INSTR_DONE,
  input wire logic        NOP_CYCLE,
  input wire logic        SKIP_TAKEN,
  input wire logic [7:0]  WORKING_REGISTER,
  input wire logic        STATUS_N,
  input wire logic        STATUS_Z,
  input wire logic [7:0]  COMPARE_DATA
);
  // ----------------
  // Properties
  // ----------------
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RST_N);
  logic [6:0] op;
  assign op = INSTR_WORD[15:9];
  // Sampled reset gates the attempt on the release edge, where the count has not moved yet
  chk_quarter_step: assert property (RST_N |=> QUARTER == $past(QUARTER) + 2'h1)
    else $error("quarter sequence broken");
  chk_done_take: assert property (INSTR_DONE |=> INSTR_TAKE)
    else $error("next instruction not taken after done");
  chk_take_first: assert property (INSTR_TAKE |-> QUARTER == `CSI_Q1 && !NOP_CYCLE)
    else $error("take outside first quarter");
  chk_done_last: assert property (INSTR_DONE |-> QUARTER == `CSI_Q4)
    else $error("done outside last quarter");
  chk_flags_kept: assert property (
    INSTR_TAKE && op[6:2] == 5'h0c |=> ($stable(STATUS_N) && $stable(STATUS_Z))[*4])
    else $error("compare changed a status flag");
  chk_equal_skip: assert property (
    INSTR_TAKE && op == `CSI_OP_CMP_EQ |-> ##4 SKIP_TAKEN == (COMPARE_DATA == WORKING_REGISTER))
    else $error("equal skip wrong");
  chk_greater_skip: assert property (
    INSTR_TAKE && op == `CSI_OP_CMP_GT |-> ##4 SKIP_TAKEN == (COMPARE_DATA > WORKING_REGISTER))
    else $error("greater skip wrong");
  chk_less_skip: assert property (
    INSTR_TAKE && op == `CSI_OP_CMP_LT |-> ##4 SKIP_TAKEN == (COMPARE_DATA < WORKING_REGISTER))
    else $error("less skip wrong");
  chk_nop_length: assert property (
    $rose(NOP_CYCLE) |-> NOP_CYCLE[*4] ##1 (!NOP_CYCLE or (NOP_CYCLE[*4] ##1 !NOP_CYCLE)))
    else $error("skip cycle count wrong");
  cov_equal_skip: cover property (INSTR_TAKE && op == `CSI_OP_CMP_EQ ##4 SKIP_TAKEN);
  cov_long_skip: cover property ($rose(NOP_CYCLE) ##7 NOP_CYCLE);
  cov_less_run: cover property (INSTR_TAKE && op == `CSI_OP_CMP_LT ##4 !SKIP_TAKEN);
endmodule
bind csi_core csi_mon u_mon (
  .CLOCK(CLOCK), .RST_N(RST_N), .INSTR_WORD(INSTR_WORD), .QUARTER(QUARTER),
  .INSTR_TAKE(INSTR_TAKE), .INSTR_DONE(INSTR_DONE), .NOP_CYCLE(NOP_CYCLE),
  .SKIP_TAKEN(SKIP_TAKEN), .WORKING_REGISTER(WORKING_REGISTER), .STATUS_N(STATUS_N),
  .STATUS_Z(STATUS_Z), .COMPARE_DATA(COMPARE_DATA));
`default_nettype wire

// ===== tb/tb_top.sv
// Self-checking bench for the compare-and-skip unit
`timescale 1ns/1ps
`default_nettype none
`include "csi_map.vh"
module tb_top;
  typedef struct {logic [7:0] len, data, w; logic skip, n, z, cmp;} csi_note_t;
  logic        CLOCK, RST_N, NEXT_IS_TWO_WORD, EXT_SET_EN, WORK_LOAD, MEM_WR_EN;
  logic [15:0] INSTR_WORD;
  logic [3:0]  BANK_SELECT_REGISTER;
  logic [11:0] INDEX_BASE, MEM_WR_ADDR;
  logic [7:0]  WORK_LOAD_DATA, MEM_WR_DATA, WORKING_REGISTER, COMPARE_DATA, f, w, d;
  logic [1:0]  QUARTER;
  logic        INSTR_TAKE, INSTR_DONE, NOP_CYCLE, SKIP_TAKEN, STATUS_N, STATUS_Z;
  logic [31:0] rnd, r2;
  logic [6:0]  op;
  logic        tw, pend, exp_n, exp_z;
  csi_note_t   nt, got;
  csi_note_t   notes[$];
  int          mismatches, samples_checked, cyc, last_done, len_seen;
  csi_core uut (
    .CLOCK(CLOCK), .RST_N(RST_N), .INSTR_WORD(INSTR_WORD),
    .NEXT_IS_TWO_WORD(NEXT_IS_TWO_WORD), .EXT_SET_EN(EXT_SET_EN),
    .BANK_SELECT_REGISTER(BANK_SELECT_REGISTER), .INDEX_BASE(INDEX_BASE),
    .WORK_LOAD(WORK_LOAD), .WORK_LOAD_DATA(WORK_LOAD_DATA), .MEM_WR_EN(MEM_WR_EN),
    .MEM_WR_ADDR(MEM_WR_ADDR), .MEM_WR_DATA(MEM_WR_DATA), .QUARTER(QUARTER),
    .INSTR_TAKE(INSTR_TAKE), .INSTR_DONE(INSTR_DONE), .NOP_CYCLE(NOP_CYCLE),
    .SKIP_TAKEN(SKIP_TAKEN), .WORKING_REGISTER(WORKING_REGISTER), .STATUS_N(STATUS_N),
    .STATUS_Z(STATUS_Z), .COMPARE_DATA(COMPARE_DATA));
  // ----------------
  // Helpers
  // ----------------
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    lfsr = {x[30:0], 1'b0} ^ (x[31] ? 32'h00400007 : 32'h0);
  endfunction
  task automatic cmp_byte(input string nm, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cmp_flag(input string nm, input logic e, input logic g);
    cmp_byte(nm, {7'h0, e}, {7'h0, g});
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Memory and working register are loaded on the take edge, before the Q2 read
  task automatic issue(input logic [15:0] iw, input logic t2, input csi_note_t n);
    INSTR_WORD <= iw;
    NEXT_IS_TWO_WORD <= t2;
    notes.push_back(n);
    @(posedge CLOCK);
    MEM_WR_EN <= 1'b0;
    WORK_LOAD <= 1'b0;
    do @(negedge CLOCK); while (INSTR_DONE !== 1'b1);
    @(posedge CLOCK);
  endtask
  // ----------------
  // Clock, watchdog, result checker
  // ----------------
  initial begin
    CLOCK = 1'b0;
    forever #2 CLOCK = ~CLOCK;
  end
  always @(posedge CLOCK) begin
    cyc <= cyc + 1;
    if (cyc > 3000) begin
      mismatches++;
      conclude();
    end
  end
  // Registered results settle one edge after done, so compare a half cycle later
  always @(negedge CLOCK) begin
    if (pend) begin
      got = notes.pop_front();
      if (len_seen != 0) cmp_byte("length", got.len, len_seen[7:0]);
      cmp_flag("skip", got.skip, SKIP_TAKEN);
      if (got.cmp) cmp_byte("data", got.data, COMPARE_DATA);
      cmp_byte("w", got.w, WORKING_REGISTER);
      cmp_flag("n", got.n, STATUS_N);
      cmp_flag("z", got.z, STATUS_Z);
    end
    pend = (INSTR_DONE === 1'b1);
    if (pend) begin
      len_seen = (last_done == 0) ? 0 : cyc - last_done;
      last_done = cyc;
    end
  end
  // ----------------
  // Stimulus
  // ----------------
  initial begin
    {RST_N, NEXT_IS_TWO_WORD, EXT_SET_EN, WORK_LOAD, MEM_WR_EN, pend} = '0;
    {INSTR_WORD, BANK_SELECT_REGISTER, INDEX_BASE, MEM_WR_ADDR} = '0;
    {WORK_LOAD_DATA, MEM_WR_DATA, exp_n, exp_z} = '0;
    rnd = 32'h92e2;
    repeat (4) @(posedge CLOCK);
    RST_N <= 1'b1;
    for (int i = 0; i < 64; i++) begin
      rnd = lfsr(lfsr(rnd));
      r2 = lfsr(rnd);
      f = rnd[27] ? 8'h5e + {6'h0, rnd[29:28]} : rnd[7:0];
      w = rnd[15:8];
      d = (i % 8 == 7) ? 8'hff : rnd[26] ? w : rnd[23:16];
      tw = rnd[30];
      op = (i % 4 == 3) ? {`CSI_OP_COMPL, i % 8 == 3} : `CSI_OP_CMP_LT + 7'(i % 4);
      nt.cmp = (i % 4 != 3);
      nt.skip = (i % 4 == 0) ? d < w : (i % 4 == 1) ? d == w : (i % 4 == 2) && d > w;
      if (!nt.cmp) begin
        exp_n = ~d[7];
        exp_z = (d == 8'hff);
      end
      nt.w = (nt.cmp || i % 8 == 3) ? w : ~d;
      nt.n = exp_n;
      nt.z = exp_z;
      nt.data = d;
      nt.len = (nt.cmp && nt.skip) ? (tw ? 8'h0c : 8'h08) : 8'h04;
      EXT_SET_EN <= r2[0];
      BANK_SELECT_REGISTER <= r2[4:1];
      INDEX_BASE <= r2[16:5];
      WORK_LOAD <= 1'b1;
      WORK_LOAD_DATA <= w;
      MEM_WR_EN <= 1'b1;
      MEM_WR_DATA <= d;
      MEM_WR_ADDR <= r2[17] ? {r2[4:1], f} : (r2[0] && f <= 8'h5f) ? r2[16:5] + {4'h0, f}
                     : {(f < 8'h60) ? 4'h0 : 4'hf, f};
      issue({op, r2[17], f}, tw, nt);
    end
    repeat (2) @(negedge CLOCK);
    conclude();
  end
endmodule
`default_nettype wire
